/* wdt_pkg.sv */
// wdt_pkg: constants, offsets and types shared by the watchdog files
package wdt_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_UNITS = 8'hF1;
  localparam logic [7:0] ADDR_VALUE = 8'hF2;
  localparam logic [7:0] ADDR_CFG = 8'hF3;
  localparam logic [7:0] ADDR_CTRL = 8'hF4;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'hF5;
  localparam logic [7:0] ADDR_EVT_MASK = 8'hF6;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int UNITS_SECONDS_BIT = 7;
  localparam int CFG_GAME_BIT = 0;
  localparam int CFG_KBD_BIT = 1;
  localparam int CFG_MOUSE_BIT = 2;
  localparam int CFG_MAP_LSB = 4;
  localparam int CTRL_STATUS_BIT = 0;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CTRL_EXT_BIT = 3;
  localparam int EVT_COUNT_BIT = 0;
  localparam int EVT_SOFT_BIT = 1;
  localparam int EVT_KBC_BIT = 2;
  localparam int EVT_WIDTH = 3;

  localparam logic [3:0] MAP_DISABLED = 4'h0;
  localparam logic [3:0] MAP_INVALID = 4'h2;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [3:0] MAP_RESET = 4'h0;
  localparam logic [2:0] CFG_EN_RESET = 3'h0;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLOCK_PERIOD_NS;
  localparam int unsigned SECONDS_PER_MINUTE = 60;

  typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_EXPIRED} wdt_state_t;

endpackage

/* wdt_tick_if.sv */
// wdt_tick_if: unit tick handshake between the watchdog core and its prescaler
`timescale 1ns/1ps
interface wdt_tick_if;
  logic restart;
  logic seconds;
  logic unitTick;
  modport gen(input restart, input seconds, output unitTick);
  modport core(output restart, output seconds, input unitTick);
endinterface

/* wdt_unit_tick.sv */
// wdt_unit_tick: prescaler giving one pulse per second or per minute
`timescale 1ns/1ps
module wdt_unit_tick #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::CYCLES_PER_SECOND
) (
  input wire logic core_clk,
  input wire logic reset,
  wdt_tick_if.gen tickPort
);
  import wdt_pkg::*;

  logic [31:0] cycleCount;
  logic [5:0] secCount;
  logic unitTick;
  logic [31:0] next_cycleCount;
  logic [5:0] next_secCount;
  logic next_unitTick;

  assign tickPort.unitTick = unitTick;

  // ************************************************************
  // prescaler
  // ************************************************************
  always_comb begin
    next_cycleCount = cycleCount + 32'h1;
    next_secCount = secCount;
    next_unitTick = 1'b0;
    if (tickPort.restart) begin
      // restart aligns the first unit to the reload moment
      next_cycleCount = 32'h0;
      next_secCount = 6'h0;
    end else if (cycleCount == TICK_CYCLES - 1) begin
      next_cycleCount = 32'h0;
      if (tickPort.seconds || secCount == 6'(SECONDS_PER_MINUTE - 1)) begin
        next_secCount = 6'h0;
        next_unitTick = 1'b1;
      end else begin
        next_secCount = secCount + 6'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cycleCount <= 32'h0;
      secCount <= 6'h0;
      unitTick <= 1'b0;
    end else begin
      cycleCount <= next_cycleCount;
      secCount <= next_secCount;
      unitTick <= next_unitTick;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  minute_tick_a: assert property (
    unitTick && !$past(tickPort.seconds) && !$past(tickPort.restart)
      |-> $past(secCount) == 6'(SECONDS_PER_MINUTE - 1))
    else $error("minute tick without full minute");

  second_tick_a: assert property (
    unitTick |-> $past(cycleCount) == TICK_CYCLES - 1)
    else $error("unit tick off the second boundary");

endmodule

/* wdt_aux_top.sv */
// wdt_aux_top: auxiliary I/O watchdog timer with its register set
`timescale 1ns/1ps
module wdt_aux_top #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::CYCLES_PER_SECOND
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic standbyReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic gamePortAccess,
  input wire logic kbdIrq,
  input wire logic mouseIrq,
  input wire logic kbcResetOutput,
  output logic [15:0] irqLines,
  output logic eventIrq,
  output logic timeoutPulse
);
  import wdt_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic wrHit(input logic we, input logic [7:0] addr,
                                 input logic [7:0] target);
    wrHit = we && (addr == target);
  endfunction

  function automatic logic [15:0] irqDecode(input logic [3:0] map);
    if (map == MAP_DISABLED || map == MAP_INVALID) begin
      irqDecode = 16'h0000;
    end else begin
      irqDecode = 16'h0001 << map;
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic unitsSeconds;
  logic [7:0] timeoutValue;
  logic [2:0] cfgEnables;
  logic [3:0] irqMap;
  logic ctrlStatus;
  logic ctrlExtEnable;
  logic [EVT_WIDTH-1:0] evtStatus;
  logic [EVT_WIDTH-1:0] evtMask;
  logic [7:0] remaining;
  wdt_state_t state;
  logic [2:0] kbcSync;
  logic kbcLevel;
  logic kbcLevelPrev;
  logic kbdPrev;
  logic mousePrev;

  logic next_unitsSeconds;
  logic [7:0] next_timeoutValue;
  logic [2:0] next_cfgEnables;
  logic [3:0] next_irqMap;
  logic next_ctrlStatus;
  logic next_ctrlExtEnable;
  logic [EVT_WIDTH-1:0] next_evtStatus;
  logic [EVT_WIDTH-1:0] next_evtMask;
  logic [7:0] next_remaining;
  wdt_state_t next_state;
  logic [2:0] next_kbcSync;
  logic next_kbcLevel;
  logic [7:0] next_regRdData;
  logic [15:0] next_irqLines;
  logic next_eventIrq;
  logic next_timeoutPulse;

  logic kbdRise;
  logic mouseRise;
  logic kbcRise;
  logic softForce;
  logic kbcForce;
  logic reloadEvent;
  logic valueWrite;
  logic restart;
  logic [7:0] loadValue;
  logic countExpire;
  logic timeoutEvent;
  logic [EVT_WIDTH-1:0] evtSet;
  logic [EVT_WIDTH-1:0] evtClear;

  wdt_tick_if tickBus();

  wdt_unit_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) unitTimer (
    .core_clk(core_clk),
    .reset(reset),
    .tickPort(tickBus.gen)
  );

  assign tickBus.restart = restart;
  assign tickBus.seconds = unitsSeconds;

  // ************************************************************
  // event detection
  // ************************************************************
  assign kbdRise = kbdIrq && !kbdPrev;
  assign mouseRise = mouseIrq && !mousePrev;
  // level may stay high for ever, so only the edge may force
  assign kbcRise = kbcLevel && !kbcLevelPrev;
  assign kbcForce = kbcRise && ctrlExtEnable;
  assign softForce = wrHit(regWrite, regAddr, ADDR_CTRL) && regWrData[CTRL_FORCE_BIT];

  assign reloadEvent = (gamePortAccess && cfgEnables[CFG_GAME_BIT])
                     || (kbdRise && cfgEnables[CFG_KBD_BIT])
                     || (mouseRise && cfgEnables[CFG_MOUSE_BIT]);
  assign valueWrite = wrHit(regWrite, regAddr, ADDR_VALUE);
  // a change of units also restarts, so no unit is half old, half new
  assign restart = reloadEvent || valueWrite || wrHit(regWrite, regAddr, ADDR_UNITS);
  assign loadValue = valueWrite ? regWrData : timeoutValue;
  assign countExpire = (state == WD_COUNT) && tickBus.unitTick
                     && (remaining == 8'h01) && !restart;
  assign timeoutEvent = countExpire || softForce || kbcForce;

  assign evtSet = {kbcForce, softForce, countExpire};
  assign evtClear = wrHit(regWrite, regAddr, ADDR_EVT_STATUS) ? regWrData[EVT_WIDTH-1:0]
                                                                : EVT_RESET;

  // ************************************************************
  // keyboard controller pin and edge history
  // ************************************************************
  always_comb begin
    next_kbcSync = {kbcSync[1:0], kbcResetOutput};
    next_kbcLevel = kbcLevel;
    if (kbcSync[1] == kbcSync[2]) begin
      next_kbcLevel = kbcSync[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      kbcSync <= 3'h0;
      kbcLevel <= 1'b0;
      kbcLevelPrev <= 1'b0;
      kbdPrev <= 1'b0;
      mousePrev <= 1'b0;
    end else begin
      kbcSync <= next_kbcSync;
      kbcLevel <= next_kbcLevel;
      kbcLevelPrev <= kbcLevel;
      kbdPrev <= kbdIrq;
      mousePrev <= mouseIrq;
    end
  end

  // ************************************************************
  // configuration registers, main reset
  // ************************************************************
  always_comb begin
    next_unitsSeconds = unitsSeconds;
    next_timeoutValue = timeoutValue;
    next_cfgEnables = cfgEnables;
    next_irqMap = irqMap;
    next_evtMask = evtMask;
    if (wrHit(regWrite, regAddr, ADDR_UNITS)) begin
      next_unitsSeconds = regWrData[UNITS_SECONDS_BIT];
    end
    if (valueWrite) begin
      next_timeoutValue = regWrData;
    end
    if (wrHit(regWrite, regAddr, ADDR_CFG)) begin
      next_cfgEnables = regWrData[2:0];
      next_irqMap = regWrData[CFG_MAP_LSB +: 4];
    end
    if (wrHit(regWrite, regAddr, ADDR_EVT_MASK)) begin
      next_evtMask = regWrData[EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      unitsSeconds <= 1'b0;
      timeoutValue <= VALUE_RESET;
      cfgEnables <= CFG_EN_RESET;
      irqMap <= MAP_RESET;
      evtMask <= EVT_RESET;
    end else begin
      unitsSeconds <= next_unitsSeconds;
      timeoutValue <= next_timeoutValue;
      cfgEnables <= next_cfgEnables;
      irqMap <= next_irqMap;
      evtMask <= next_evtMask;
    end
  end

  // ************************************************************
  // control register, standby reset only
  // ************************************************************
  always_comb begin
    next_ctrlStatus = ctrlStatus;
    next_ctrlExtEnable = ctrlExtEnable;
    if (wrHit(regWrite, regAddr, ADDR_CTRL)) begin
      next_ctrlStatus = regWrData[CTRL_STATUS_BIT];
      next_ctrlExtEnable = regWrData[CTRL_EXT_BIT];
    end
    // a timeout in the cycle of a clearing write still lands
    if (timeoutEvent) begin
      next_ctrlStatus = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (standbyReset) begin
      ctrlStatus <= 1'b0;
      ctrlExtEnable <= 1'b0;
    end else begin
      ctrlStatus <= next_ctrlStatus;
      ctrlExtEnable <= next_ctrlExtEnable;
    end
  end

  // ************************************************************
  // countdown
  // ************************************************************
  always_comb begin
    next_state = state;
    next_remaining = remaining;
    if (restart) begin
      if (loadValue == 8'h00) begin
        next_state = WD_IDLE;
        next_remaining = 8'h00;
      end else begin
        next_state = WD_COUNT;
        next_remaining = loadValue;
      end
    end else begin
      unique case (state)
        WD_IDLE: begin
          next_remaining = 8'h00;
        end
        WD_COUNT: begin
          if (tickBus.unitTick) begin
            if (remaining == 8'h01) begin
              next_state = WD_EXPIRED;
              next_remaining = 8'h00;
            end else begin
              next_remaining = remaining - 8'h01;
            end
          end
        end
        WD_EXPIRED: begin
          next_remaining = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= WD_IDLE;
      remaining <= 8'h00;
    end else begin
      state <= next_state;
      remaining <= next_remaining;
    end
  end

  // ************************************************************
  // event status, read port and outputs
  // ************************************************************
  always_comb begin
    next_evtStatus = (evtStatus & ~evtClear) | evtSet;
    next_irqLines = ctrlStatus ? irqDecode(irqMap) : 16'h0000;
    next_eventIrq = |(next_evtStatus & evtMask);
    next_timeoutPulse = timeoutEvent;
    next_regRdData = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        ADDR_UNITS: next_regRdData = {unitsSeconds, 7'h00};
        ADDR_VALUE: next_regRdData = timeoutValue;
        ADDR_CFG: next_regRdData = {irqMap, 1'b0, cfgEnables};
        // force bit is write-only and reads as zero
        ADDR_CTRL: next_regRdData = {4'h0, ctrlExtEnable, 2'h0, ctrlStatus};
        ADDR_EVT_STATUS: next_regRdData = {5'h00, evtStatus};
        ADDR_EVT_MASK: next_regRdData = {5'h00, evtMask};
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      evtStatus <= EVT_RESET;
      irqLines <= 16'h0000;
      eventIrq <= 1'b0;
      timeoutPulse <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      evtStatus <= next_evtStatus;
      irqLines <= next_irqLines;
      eventIrq <= next_eventIrq;
      timeoutPulse <= next_timeoutPulse;
      regRdData <= next_regRdData;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || standbyReset);

  units_readback_a: assert property (
    wrHit(regWrite, regAddr, ADDR_UNITS) ##1 (regRead && regAddr == ADDR_UNITS)
      |=> regRdData == ($past(regWrData, 2) & 8'h80))
    else $error("units readback wrong");

  zero_disable_a: assert property (
    timeoutValue == 8'h00 && !valueWrite |-> !countExpire && state != WD_COUNT)
    else $error("count active with zero value");

  count_step_a: assert property (
    state == WD_COUNT && tickBus.unitTick && remaining > 8'h01 && !restart
      |=> remaining == $past(remaining) - 8'h01)
    else $error("countdown step wrong");

  reload_load_a: assert property (
    reloadEvent && !valueWrite && timeoutValue != 8'h00
      |=> state == WD_COUNT && remaining == $past(timeoutValue))
    else $error("reload did not restart count");

  no_reload_a: assert property (
    !restart && !tickBus.unitTick |=> remaining == $past(remaining))
    else $error("count moved without cause");

  irq_map_a: assert property (
    ctrlStatus && !$changed(irqMap) && !$changed(ctrlStatus)
      |-> ##1 irqLines == irqDecode($past(irqMap)))
    else $error("interrupt line mapping wrong");

  invalid_map_a: assert property (
    irqMap == MAP_INVALID && $stable(irqMap) |=> irqLines == 16'h0000)
    else $error("invalid map drove a line");

  status_read_a: assert property (
    regRead && regAddr == ADDR_CTRL |=> regRdData[0] == $past(ctrlStatus)
      && regRdData[2] == 1'b0)
    else $error("control read wrong");

  soft_force_a: assert property (
    softForce |=> ctrlStatus && timeoutPulse ##1 (!timeoutPulse || $past(timeoutEvent)))
    else $error("software force lost");

  kbc_force_a: assert property (
    $rose(kbcLevel) && ctrlExtEnable |=> ##[0:1] (ctrlStatus && timeoutPulse))
    else $error("external force lost");

  kbc_blocked_a: assert property (
    !ctrlExtEnable && !softForce && !countExpire |=> !timeoutPulse)
    else $error("timeout without enabled cause");

  expire_status_a: assert property (
    countExpire |=> ctrlStatus && state == WD_EXPIRED && evtStatus[EVT_COUNT_BIT])
    else $error("expiry did not set status");

endmodule

/* wdt_aux_top_bench.sv */
// wdt_aux_top_bench: self-checking bench for the auxiliary I/O watchdog
`timescale 1ns/1ps
module wdt_aux_top_bench;
  import wdt_pkg::*;
  // short unit so a minute is 600 cycles
  localparam int TICKS = 10;
  logic core_clk, reset, standbyReset, regWrite, regRead;
  logic [7:0] regAddr, regWrData, regRdData;
  logic gamePortAccess, kbdIrq, mouseIrq, kbcResetOutput, eventIrq, timeoutPulse;
  logic [15:0] irqLines;
  int errTotal = 0;
  int comparisons = 0;
  int pulseCount = 0;
  int cycles = 0;

  wdt_aux_top #(.TICK_CYCLES(TICKS)) wdt_aux_top_i (
    .core_clk(core_clk),
    .reset(reset),
    .standbyReset(standbyReset),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .gamePortAccess(gamePortAccess),
    .kbdIrq(kbdIrq),
    .mouseIrq(mouseIrq),
    .kbcResetOutput(kbcResetOutput),
    .irqLines(irqLines),
    .eventIrq(eventIrq),
    .timeoutPulse(timeoutPulse)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulses are counted, so a double pulse shows up as a count error
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (timeoutPulse === 1'b1) begin
      pulseCount <= pulseCount + 1;
    end
    if (cycles == 20000) begin
      errTotal++;
      results();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkFlag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chkVal(what, {8'h00, exp}, {8'h00, regRdData});
  endtask

  // write then read back with no gap between the strobes
  task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
                      input string what);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chkVal(what, {8'h00, exp}, {8'h00, regRdData});
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic expectPulse(input int lo, input int hi, input string what);
    int c;
    int p0;
    c = 0;
    p0 = pulseCount;
    while (pulseCount == p0 && c < hi) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    chkFlag(what, 1'b1, pulseCount != p0 && c >= lo);
  endtask

  task automatic kick(input int s);
    @(posedge core_clk);
    gamePortAccess <= (s == 0);
    kbdIrq <= (s == 1);
    mouseIrq <= (s == 2);
    @(posedge core_clk);
    gamePortAccess <= 1'b0;
    kbdIrq <= 1'b0;
    mouseIrq <= 1'b0;
  endtask

  task automatic clearAll();
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_EVT_STATUS, 8'h07);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic testRegs();
    rd(ADDR_UNITS, 8'h00, "units reset");
    rd(ADDR_VALUE, 8'h00, "value reset");
    rd(ADDR_CFG, 8'h00, "cfg reset");
    rd(ADDR_CTRL, 8'h00, "ctrl reset");
    rd(ADDR_EVT_STATUS, 8'h00, "event status reset");
    rd(ADDR_EVT_MASK, 8'h00, "event mask reset");
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00, "unmapped read");
    wrRd(ADDR_UNITS, 8'hFF, 8'h80, "units reserved");
    wr(ADDR_CFG, 8'hFF);
    rd(ADDR_CFG, 8'hF7, "cfg reserved");
    wr(ADDR_CFG, 8'h00);
    chkVal("irq idle", 16'h0000, irqLines);
    $display("test registers done");
  endtask

  task automatic testSeconds();
    logic [7:0] vals [3] = '{8'h01, 8'h03, 8'hFF};
    wr(ADDR_UNITS, 8'h80);
    wr(ADDR_CFG, 8'h30);
    wr(ADDR_EVT_MASK, 8'h07);
    foreach (vals[i]) begin
      wr(ADDR_VALUE, vals[i]);
      rd(ADDR_CTRL, 8'h00, "status counting");
      expectPulse(int'(vals[i]) * TICKS - 5, int'(vals[i]) * TICKS + 6, "expiry");
      waitCyc(3);
      rd(ADDR_CTRL, 8'h01, "status expired");
      chkVal("irq line 3", 16'h0008, irqLines);
      chkFlag("event irq", 1'b1, eventIrq);
      rd(ADDR_EVT_STATUS, 8'h01, "count event");
      clearAll();
      waitCyc(3);
      chkVal("irq cleared", 16'h0000, irqLines);
      chkFlag("event irq cleared", 1'b0, eventIrq);
    end
    wr(ADDR_VALUE, 8'h00);
    waitCyc(40);
    chkFlag("zero disables", 1'b1, eventIrq === 1'b0 && irqLines === 16'h0000);
    wr(ADDR_UNITS, 8'h00);
    wr(ADDR_VALUE, 8'h01);
    expectPulse(60 * TICKS - 3, 60 * TICKS + 6, "minute expiry");
    clearAll();
    $display("test counting done");
  endtask

  task automatic testReload();
    int p0;
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_UNITS, 8'h80);
      wr(ADDR_CFG, 8'(1 << s));
      wr(ADDR_VALUE, 8'h02);
      p0 = pulseCount;
      repeat (5) begin
        waitCyc(12);
        kick(s);
      end
      chkFlag("reload holds off", 1'b1, pulseCount == p0);
      wr(ADDR_CFG, 8'h00);
      repeat (3) begin
        waitCyc(12);
        kick(s);
      end
      chkFlag("disabled reload", 1'b1, pulseCount == p0 + 1);
      clearAll();
    end
    $display("test reload done");
  endtask

  task automatic testForce();
    int p0;
    wr(ADDR_EVT_MASK, 8'h00);
    wr(ADDR_CFG, 8'h50);
    p0 = pulseCount;
    wr(ADDR_CTRL, 8'h04);
    waitCyc(3);
    chkFlag("force pulse", 1'b1, pulseCount == p0 + 1);
    rd(ADDR_CTRL, 8'h01, "force self clear");
    rd(ADDR_EVT_STATUS, 8'h02, "force event");
    chkVal("irq line 5", 16'h0020, irqLines);
    chkFlag("masked event", 1'b0, eventIrq);
    wr(ADDR_EVT_MASK, 8'h02);
    waitCyc(3);
    chkFlag("unmasked event", 1'b1, eventIrq);
    wr(ADDR_EVT_STATUS, 8'h02);
    waitCyc(3);
    chkFlag("event w1c", 1'b0, eventIrq);
    chkVal("status kept", 16'h0020, irqLines);
    // status stays set, so each map code other than 0 and 2 shows directly on the lines
    for (int m = 0; m < 16; m++) begin
      wr(ADDR_CFG, 8'(m << 4));
      waitCyc(3);
      chkVal("irq map", (m == 0 || m == 2) ? 16'h0000 : 16'h0001 << m, irqLines);
    end
    clearAll();
    $display("test force done");
  endtask

  task automatic testKbc();
    int p0;
    p0 = pulseCount;
    @(posedge core_clk);
    kbcResetOutput <= 1'b1;
    waitCyc(20);
    chkFlag("edge ignored", 1'b1, pulseCount == p0);
    @(posedge core_clk);
    kbcResetOutput <= 1'b0;
    waitCyc(10);
    wr(ADDR_CTRL, 8'h08);
    @(posedge core_clk);
    kbcResetOutput <= 1'b1;
    waitCyc(40);
    chkFlag("one pulse per edge", 1'b1, pulseCount == p0 + 1);
    rd(ADDR_EVT_STATUS, 8'h04, "kbc event");
    rd(ADDR_CTRL, 8'h09, "kbc status");
    wr(ADDR_CTRL, 8'h0C);
    waitCyc(3);
    chkFlag("force with ext", 1'b1, pulseCount == p0 + 2);
    @(posedge core_clk);
    kbcResetOutput <= 1'b0;
    $display("test kbc done");
  endtask

  task automatic testResets();
    wr(ADDR_UNITS, 8'h80);
    wr(ADDR_VALUE, 8'h05);
    wr(ADDR_CFG, 8'h31);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_UNITS, 8'h00, "units main reset");
    rd(ADDR_VALUE, 8'h00, "value main reset");
    rd(ADDR_CFG, 8'h00, "cfg main reset");
    rd(ADDR_CTRL, 8'h09, "ctrl kept");
    @(posedge core_clk);
    standbyReset <= 1'b1;
    @(posedge core_clk);
    standbyReset <= 1'b0;
    rd(ADDR_CTRL, 8'h00, "ctrl standby reset");
    $display("test resets done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    standbyReset = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    gamePortAccess = 1'b0;
    kbdIrq = 1'b0;
    mouseIrq = 1'b0;
    kbcResetOutput = 1'b0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    standbyReset <= 1'b0;
    testRegs();
    testSeconds();
    testReload();
    testForce();
    testKbc();
    testResets();
    results();
  end
endmodule
